// [include/dcc_pkg.sv]
/*
 package of constants for the dual channel converter control block.
 assumes a 32-bit apb slave, byte addresses, one aligned word per register.
*/
package dcc_pkg;
   localparam logic [11:0] ADDR_CHAN0_CODE   = 12'h000;
   localparam logic [11:0] ADDR_CHAN1_CODE   = 12'h004;
   localparam logic [11:0] ADDR_CONTROL      = 12'h008;
   localparam logic [11:0] ADDR_STATUS       = 12'h00C;
   localparam logic [11:0] ADDR_MODULE_STOP  = 12'h010;
   localparam int          BIT_CHAN1_OE      = 7;
   localparam int          BIT_CHAN0_OE      = 6;
   localparam int          BIT_JOINT_EN      = 5;
   localparam logic [4:0]  CONTROL_RSVD_VAL  = 5'h1F;
   localparam logic [7:0]  CODE_RESET        = 8'h00;
   localparam logic        MSTOP_RESET       = 1'b1;
   localparam int          CLK_FREQ_HZ       = 10_000_000;
   localparam int          CONV_TIME_NS      = 10_000;
   localparam int          CONV_CYCLES       = (CONV_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
endpackage

// [hdl/dcc_channel.sv]
/*
 one converter channel: holds the presented code and times each conversion.
 assumes start pulses and enable levels come from logic on the same clock.
*/
`timescale 1ns/1ns
module dcc_channel #(
   parameter int CONV_CYCLES = dcc_pkg::CONV_CYCLES
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       convert_en,
   input  wire logic       drive_en,
   input  wire logic       standby,
   input  wire logic       start,
   input  wire logic [7:0] code,
   output logic [7:0]      out_code,
   output logic            out_valid,
   output logic            busy
);
   import dcc_pkg::*;
   localparam int CW = $clog2(CONV_CYCLES + 1);
   initial begin
      if (CONV_CYCLES < 1) $error("conversion time must be at least one cycle");
   end
   typedef struct packed {
      logic [CW-1:0] count;
      logic          running;
      logic          pending;
      logic          valid;
      logic [7:0]    result;
   } dcc_chan_state_type;
   dcc_chan_state_type state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      if (standby) begin
         state_next = state_reg; // outputs held during standby
         // a write made in standby is kept so it still restarts afterwards
         state_next.pending = state_reg.pending | start;
      end else if (!convert_en) begin
         state_next.running = 1'b0; // circuit inactive
         state_next.valid   = 1'b0;
         state_next.count   = '0;
         state_next.pending = 1'b0;
      end else if (start || state_reg.pending || (!state_reg.running && !state_reg.valid)) begin
         state_next.pending = 1'b0;
         state_next.running = 1'b1; // restart on write or enable
         state_next.count   = CW'(CONV_CYCLES - 1);
         state_next.result  = code; // code passed unmodified
         if (start || state_reg.pending) state_next.valid = 1'b0;
      end else if (state_reg.running) begin
         if (state_reg.count == '0) begin
            state_next.running = 1'b0;
            state_next.valid   = 1'b1; // result presented after conversion time
         end else begin
            state_next.count = state_reg.count - CW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '{count: '0, running: 1'b0, pending: 1'b0, valid: 1'b0, result: CODE_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   // pins show the result only while the output enable is set
   assign out_code  = (drive_en && state_reg.valid) ? state_reg.result : 8'h00;
   assign out_valid = drive_en && state_reg.valid;
   assign busy      = state_reg.running;
endmodule

// [hdl/dcc_top.sv]
/*
 dual channel converter control with apb register slave.
 assumes standby input is synchronous to pclk; analog circuits read out codes.
*/
// Function
// - bit 7 set enables channel 1 conversion and drives its output.
// - bit 6 set enables channel 0 conversion and drives its output.
// - bit 5 clear: own enables convert; set: both channels convert.
// - output pins follow output enables only, never the joint enable.
// - all three bits clear keeps both converters inactive.
// - joint enable alone converts both channels, drives neither pin.
// - control bits 4 to 0 read as one, writes ignored.
// - result appears after conversion time, held until rewrite or disable.
// - data write to enabled channel restarts conversion next cycle; in standby, once standby ends.
// - code passes unmodified to the converter.
// - clearing an output enable stops driving that pin.
// - starts in module stop, refusing access to every register but module stop until cleared.
// - software standby holds enabled outputs at present values.
// - each channel has an eight-bit data register resetting to zero.
`timescale 1ns/1ns
module dcc_top #(
   parameter int CONV_CYCLES = dcc_pkg::CONV_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        standby,
   output logic [7:0]       chan0_analog_out,
   output logic [7:0]       chan1_analog_out,
   output logic             chan0_drive,
   output logic             chan1_drive,
   output logic             chan0_convert,
   output logic             chan1_convert,
   output logic [1:0]       result_valid
);
   import dcc_pkg::*;
   typedef struct packed {
      logic [7:0]  chan0_code;
      logic [7:0]  chan1_code;
      logic        chan1_output_enable;
      logic        chan0_output_enable;
      logic        joint_convert_enable;
      logic        module_stop;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic [1:0]  start;
      logic [7:0]  out0;
      logic [7:0]  out1;
      logic [1:0]  drive;
      logic [1:0]  conv;
      logic [1:0]  valid;
   } dcc_state_type;
   dcc_state_type state_reg, state_next;

   logic [7:0] code0_q, code1_q;
   logic       valid0, valid1, busy0, busy1;
   logic       conv0_en, conv1_en;
   logic       access, wr;
   logic [7:0] control_view;

   // joint enable forces both converters on; otherwise per channel
   assign conv0_en = state_reg.joint_convert_enable | state_reg.chan0_output_enable;
   assign conv1_en = state_reg.joint_convert_enable | state_reg.chan1_output_enable;
   assign access   = psel && penable && !state_reg.ready;
   assign wr       = access && pwrite;
   // reserved low bits always read as ones
   assign control_view = {state_reg.chan1_output_enable, state_reg.chan0_output_enable,
                          state_reg.joint_convert_enable, CONTROL_RSVD_VAL};

   always_comb begin
      state_next       = state_reg;
      state_next.ready = 1'b0;
      state_next.slverr = 1'b0;
      state_next.start = 2'b00;
      if (access) begin
         state_next.ready = 1'b1;
         state_next.rdata = 32'h0000_0000;
         // register access refused while module stop is set, except to the module stop register
         if (state_reg.module_stop && paddr != ADDR_MODULE_STOP) begin
            state_next.slverr = 1'b1;
         end else begin
            unique case (paddr)
               ADDR_CHAN0_CODE: begin
                  state_next.rdata = {24'h00_0000, state_reg.chan0_code};
                  if (wr) begin
                     state_next.chan0_code = pwdata[7:0];
                     state_next.start[0]   = 1'b1;
                  end
               end
               ADDR_CHAN1_CODE: begin
                  state_next.rdata = {24'h00_0000, state_reg.chan1_code};
                  if (wr) begin
                     state_next.chan1_code = pwdata[7:0];
                     state_next.start[1]   = 1'b1;
                  end
               end
               ADDR_CONTROL: begin
                  state_next.rdata = {24'h00_0000, control_view};
                  if (wr) begin
                     state_next.chan1_output_enable  = pwdata[BIT_CHAN1_OE];
                     state_next.chan0_output_enable  = pwdata[BIT_CHAN0_OE];
                     state_next.joint_convert_enable = pwdata[BIT_JOINT_EN]; // low bits dropped
                  end
               end
               ADDR_STATUS: begin
                  state_next.rdata = {28'h000_0000, busy1, busy0, valid1, valid0};
               end
               ADDR_MODULE_STOP: begin
                  state_next.rdata = {31'h0000_0000, state_reg.module_stop};
                  if (wr) state_next.module_stop = pwdata[0];
               end
               default: begin
                  state_next.slverr = 1'b1;
               end
            endcase
         end
      end
      state_next.out0  = code0_q;
      state_next.out1  = code1_q;
      state_next.drive = {state_reg.chan1_output_enable, state_reg.chan0_output_enable};
      state_next.conv  = {conv1_en, conv0_en} & {2{~state_reg.module_stop}};
      state_next.valid = {valid1, valid0};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
         state_reg.module_stop <= MSTOP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // module stop halts both channels, like a cleared enable
   dcc_channel #(.CONV_CYCLES(CONV_CYCLES)) u_chan0 (
      .pclk       (pclk),
      .presetn    (presetn),
      .convert_en (conv0_en && !state_reg.module_stop),
      .drive_en   (state_reg.chan0_output_enable),
      .standby    (standby),
      .start      (state_reg.start[0]),
      .code       (state_reg.chan0_code),
      .out_code   (code0_q),
      .out_valid  (valid0),
      .busy       (busy0)
   );
   dcc_channel #(.CONV_CYCLES(CONV_CYCLES)) u_chan1 (
      .pclk       (pclk),
      .presetn    (presetn),
      .convert_en (conv1_en && !state_reg.module_stop),
      .drive_en   (state_reg.chan1_output_enable),
      .standby    (standby),
      .start      (state_reg.start[1]),
      .code       (state_reg.chan1_code),
      .out_code   (code1_q),
      .out_valid  (valid1),
      .busy       (busy1)
   );

   assign prdata           = state_reg.rdata;
   assign pready           = state_reg.ready;
   assign pslverr          = state_reg.slverr;
   assign chan0_analog_out = state_reg.out0;
   assign chan1_analog_out = state_reg.out1;
   assign chan0_drive      = state_reg.drive[0];
   assign chan1_drive      = state_reg.drive[1];
   assign chan0_convert    = state_reg.conv[0];
   assign chan1_convert    = state_reg.conv[1];
   assign result_valid     = state_reg.valid;
endmodule

// [sim/dcc_monitor.sv]
/*
 checker for the converter control ports: bus answer timing and channel outputs.
 assumes it is bound to dcc_top and that module stop is not set again after use.
*/
`timescale 1ns/1ns
module dcc_monitor (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        standby,
   input  wire logic [7:0]  chan0_analog_out,
   input  wire logic [7:0]  chan1_analog_out,
   input  wire logic        chan0_drive,
   input  wire logic        chan1_drive,
   input  wire logic        chan0_convert,
   input  wire logic        chan1_convert,
   input  wire logic [1:0]  result_valid
);
   import dcc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_next_a: assert property (psel && penable && !pready |=> pready) else $error("access not answered");
   answer_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   refuse_pair_a: assert property (pslverr |-> pready) else $error("error without ready");
   valid0_drive_a: assert property (result_valid[0] |-> chan0_drive && chan0_convert) else $error("valid0 undriven");
   valid1_drive_a: assert property (result_valid[1] |-> chan1_drive && chan1_convert) else $error("valid1 undriven");
   drive_conv_a: assert property ((chan0_drive |-> chan0_convert) and (chan1_drive |-> chan1_convert))
      else $error("pin driven without conversion");
   off_zero_a: assert property ($fell(chan0_drive) |-> ##[0:2] chan0_analog_out == 8'h00)
      else $error("output kept after disable");
   standby_hold_a: assert property (standby [*3] |-> $stable(chan0_analog_out) && $stable(chan1_analog_out))
      else $error("output moved in standby");
   restart_clr_a: assert property (psel && penable && pready && pwrite && !pslverr && !standby
      && paddr == ADDR_CHAN0_CODE |-> ##[1:3] !result_valid[0]) else $error("rewrite kept old result");
   idle_off_a: assert property (!chan0_convert && !chan1_convert && !$past(chan0_convert) && !$past(chan1_convert)
      |-> result_valid == 2'b00) else $error("result while inactive");
endmodule
bind dcc_top dcc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .standby(standby), .chan0_analog_out(chan0_analog_out),
   .chan1_analog_out(chan1_analog_out), .chan0_drive(chan0_drive), .chan1_drive(chan1_drive),
   .chan0_convert(chan0_convert), .chan1_convert(chan1_convert), .result_valid(result_valid));

// [sim/dcc_conv_model.sv]
/*
 behavioural analog side: turns a presented code into a pin level in millivolts.
 assumes an ideal converter; an undriven pin reads as minus one.
*/
`timescale 1ns/1ns
module dcc_conv_model #(
   parameter int VREF_MV = 2560
) (
   input  wire logic [7:0] code,
   input  wire logic       drive,
   output int              level_mv
);
   // pin floats unless its own drive is set
   assign level_mv = (drive === 1'b1) ? (int'(code) * VREF_MV) / 256 : -1;
endmodule

// [sim/test_dcc_top.sv]
/*
 self-checking bench for dcc_top: control table, results, restart, standby.
 assumes apb answers by pready and conversion time parameter set to 3.
*/
`timescale 1ns/1ns
module test_dcc_top;
   import dcc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, chan0_drive, chan1_drive, chan0_convert, chan1_convert;
   logic [7:0] chan0_analog_out, chan1_analog_out;
   logic [1:0] result_valid;
   int level0, level1, errors = 0, tests_run = 0;
   // rows: control bits 7..5, then drive1 drive0 convert1 convert0
   logic [6:0] rows [8] = '{7'b000_0000, 7'b001_0011, 7'b010_0101, 7'b011_0111,
                            7'b100_1010, 7'b101_1011, 7'b110_1111, 7'b111_1111};
   always #50 pclk = ~pclk;
   dcc_top #(.CONV_CYCLES(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby(standby), .chan0_analog_out(chan0_analog_out), .chan1_analog_out(chan1_analog_out),
      .chan0_drive(chan0_drive), .chan1_drive(chan1_drive), .chan0_convert(chan0_convert),
      .chan1_convert(chan1_convert), .result_valid(result_valid));
   dcc_conv_model conv0 (.code(chan0_analog_out), .drive(chan0_drive), .level_mv(level0));
   dcc_conv_model conv1 (.code(chan1_analog_out), .drive(chan1_drive), .level_mv(level1));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task wait_valid(input int ch);
      // bounded: conversion of three cycles plus pipeline
      for (int n = 0; n < 20 && result_valid[ch] !== 1'b1; n++) @(posedge pclk);
      chk(result_valid[ch], 1'b1);
   endtask
   task complete_run;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #2_000_000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(1, ADDR_CONTROL, 32'h0000_00E0);
      chk(err, 1'b1);
      chk(chan0_drive, 1'b0);
      apb(0, ADDR_MODULE_STOP, 0);
      chk(rd, 32'h0000_0001);
      apb(1, ADDR_MODULE_STOP, 0);
      apb(0, ADDR_CHAN0_CODE, 0);
      chk(err, 1'b0);
      chk(rd, 32'h0000_0000);
      apb(0, 12'h020, 0);
      chk(err, 1'b1);
      apb(1, ADDR_CHAN0_CODE, 32'h0000_00A5);
      apb(1, ADDR_CHAN1_CODE, 32'h0000_003C);
      foreach (rows[i]) begin
         apb(1, ADDR_CONTROL, {24'h0, rows[i][6:4], 5'h00});
         repeat (2) @(posedge pclk);
         chk({chan1_drive, chan0_drive, chan1_convert, chan0_convert}, rows[i][3:0]);
         apb(0, ADDR_CONTROL, 0);
         chk(rd, {24'h0, rows[i][6:4], CONTROL_RSVD_VAL});
      end
      wait_valid(0);
      wait_valid(1);
      chk({chan1_analog_out, chan0_analog_out}, 16'h3CA5);
      chk(level0, 32'd1650);
      chk(level1, 32'd600);
      apb(1, ADDR_CHAN0_CODE, 32'h0000_005A);
      repeat (2) @(posedge pclk);
      chk(result_valid[0], 1'b0);
      wait_valid(0);
      chk(chan0_analog_out, 8'h5A);
      standby <= 1;
      apb(1, ADDR_CHAN0_CODE, 32'h0000_000F);
      repeat (10) @(posedge pclk);
      chk(chan0_analog_out, 8'h5A);
      standby <= 0;
      repeat (3) @(posedge pclk);
      wait_valid(0);
      chk(chan0_analog_out, 8'h0F);
      apb(1, ADDR_CONTROL, 32'h0000_0080);
      repeat (3) @(posedge pclk);
      chk({chan0_drive, chan0_analog_out, chan1_analog_out}, 17'h0_003C);
      chk(level0, 32'hFFFF_FFFF);
      complete_run();
   end
endmodule
